/* File: design/mme_core.sv */
module mme_core
	import mme_pkg::*;
(
	input  wire logic       MCLK_I,         // core clock
	input  wire logic       RST_N_I,        // synchronous reset, active low
	input  wire logic [5:0] REG_ADDR_I,     // register address
	input  wire logic [7:0] REG_WDATA_I,    // register write data
	input  wire logic       REG_WR_I,       // write strobe
	input  wire logic       REG_RD_I,       // read strobe
	output logic      [7:0] REG_RDATA_O,    // read data, cycle after strobe
	input  wire mme_instr_t INSTR_I,        // instruction bytes, b0 first
	input  wire logic       INSTR_VALID_I,  // instruction offered
	output logic            INSTR_READY_O,  // instruction taken when both high
	output logic     [15:0] CODE_ADDR_O,    // program memory address
	output logic            CODE_RD_O,      // program memory read pulse
	input  wire logic [7:0] CODE_DATA_I,    // code byte, cycle after pulse
	output logic      [7:0] P0_O,           // port0 drive value
	output logic            P0_OE_O,        // port0 driven
	input  wire logic [7:0] P0_I,           // port0 pin level
	output logic      [7:0] P2_O,           // port2 drive value
	output logic            P2_OE_O,        // port2 driven
	input  wire logic [7:0] P2_I,           // port2 pin level
	output logic            ALE_O,          // address latch enable
	output logic            RD_N_O,         // external read strobe
	output logic            WR_N_O          // external write strobe
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]  rf [RF_BYTES];   // byte_reg file, words big-endian
	logic [7:0]  acc;             // accumulator
	logic [15:0] data_pointer;    // pointer_high_byte:pointer_low_byte
	logic [15:0] pc;              // program counter
	logic [7:0]  upper_port_latch; // software value of port2
	logic [7:0]  ctrl;            // mode and bank
	mme_flags_t  flg;             // arithmetic flags
	logic        ill;             // sticky illegal encoding
	mme_state_t  state;           // sequencer state
	logic [2:0]  cnt;             // phase counter
	logic        xwr;             // external cycle is a write
	logic [7:0]  xlo;             // address byte on port0
	logic [7:0]  xhi;             // address byte on port2
	logic [7:0]  p0_s1, p0_s2, p0_s3;  // port0 input synchroniser
	logic [7:0]  p2_s1, p2_s2, p2_s3;  // port2 input synchroniser

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic        pre;    // first byte is the escape prefix
	logic [7:0]  op;     // opcode after prefix
	logic [7:0]  x;      // operand bytes after opcode
	logic [7:0]  y;
	logic [7:0]  z;
	logic        ext;    // extended register-file encoding
	logic        xop;    // external_data_move
	logic        legal;  // encoding accepted
	logic [15:0] len;    // instruction length in bytes
	logic        go;     // instruction taken this cycle
	logic        go_ok;  // legal instruction taken

	// strips the prefix and classifies the opcode
	always_comb begin
		pre   = INSTR_I.b0 == OP_PREFIX;
		op    = pre ? INSTR_I.b1 : INSTR_I.b0;
		x     = pre ? INSTR_I.b2 : INSTR_I.b1;
		y     = pre ? INSTR_I.b3 : INSTR_I.b2;
		z     = pre ? INSTR_I.b4 : INSTR_I.b3;
		ext   = 1'b0;
		xop   = 1'b0;
		legal = 1'b1;
		len   = LEN_ONE;
		case (op)
			OP_LDPTR: len = LEN_THREE;
			OP_CTAB_PC, OP_CTAB_PTR: len = LEN_ONE;
			OP_XRD_PTR, OP_XRD_R0, OP_XRD_R1,
			OP_XWR_PTR, OP_XWR_R0, OP_XWR_R1: xop = 1'b1;
			OP_HIWORD: begin
				// only the immediate form, and only dwords inside the file
				ext   = 1'b1;
				len   = LEN_FOUR;
				legal = (x[3:0] == NIB_HIWORD) && !x[7];
			end
			OP_SEXT, OP_ZEXT, OP_MULB, OP_MULW: begin
				// register operands only, no memory form exists
				ext = 1'b1;
				len = LEN_TWO;
			end
			default: legal = 1'b0;  // outside this group
		endcase
		// binary mode wants the prefix, source mode refuses it
		if (ext)
			legal = legal && (pre != ctrl[CTL_SRC]);
		else if (pre)
			legal = 1'b0;
		if (pre)
			len = len + LEN_ONE;
		go    = INSTR_VALID_I && INSTR_READY_O;
		go_ok = go && legal;
	end

	// ----------------------------------------------------------------
	// operands and products
	// ----------------------------------------------------------------
	logic [7:0]  a8;   // destination byte
	logic [7:0]  b8;   // source byte
	logic [15:0] a16;  // destination word
	logic [15:0] b16;  // source word
	logic [15:0] p16;  // byte product
	logic [31:0] p32;  // word product
	logic [7:0]  ri;   // bank_indirect_reg of active bank

	// unsigned products; the full width never overflows its target
	always_comb begin
		a8  = rf[{1'b0, x[7:4]}];
		b8  = rf[{1'b0, x[3:0]}];
		a16 = {rf[{x[7:4], 1'b0}], rf[{x[7:4], 1'b1}]};
		b16 = {rf[{x[3:0], 1'b0}], rf[{x[3:0], 1'b1}]};
		p16 = a8 * b8;
		p32 = a16 * b16;
		ri  = rf[{ctrl[CTL_BANK+1:CTL_BANK], 2'b00, op[0]}];
	end

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic       stable;  // selected port agrees in stages two and three
	logic [7:0] xin;     // settled read data
	logic       xcap;    // read data taken this cycle

	// three stages, the pins are asynchronous to the core
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			{p0_s1, p0_s2, p0_s3} <= '0;
			{p2_s1, p2_s2, p2_s3} <= '0;
		end else begin
			{p0_s3, p0_s2, p0_s1} <= {p0_s2, p0_s1, P0_I};
			{p2_s3, p2_s2, p2_s1} <= {p2_s2, p2_s1, P2_I};
		end
	end

	// page mode reads on port2, nonpage on port0
	always_comb begin
		stable = ctrl[CTL_PAGE] ? (p2_s2 == p2_s3) : (p0_s2 == p0_s3);
		xin    = ctrl[CTL_PAGE] ? p2_s3 : p0_s3;
		xcap   = (state == S_XDATA) && (cnt == 3'h0) && !xwr && stable;
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	// instruction results land after the bus write, so they win a tie
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			for (int i = 0; i < RF_BYTES; i++)
				rf[i] <= 8'h00;
		end else begin
			if (REG_WR_I && !REG_ADDR_I[5])
				rf[REG_ADDR_I[4:0]] <= REG_WDATA_I;
			if (go_ok) begin
				case (op)
					OP_HIWORD: begin
						rf[{x[6:4], 2'b00}] <= y;
						rf[{x[6:4], 2'b01}] <= z;
					end
					OP_SEXT: begin
						rf[{x[7:4], 1'b0}] <= {8{b8[7]}};
						rf[{x[7:4], 1'b1}] <= b8;
					end
					OP_ZEXT: begin
						rf[{x[7:4], 1'b0}] <= 8'h00;
						rf[{x[7:4], 1'b1}] <= b8;
					end
					OP_MULB: begin
						// word holding the destination, odd or even
						rf[{1'b0, x[7:5], 1'b0}] <= p16[15:8];
						rf[{1'b0, x[7:5], 1'b1}] <= p16[7:0];
					end
					OP_MULW: begin
						// dword holding the destination word
						rf[{x[7:5], 2'b00}] <= p32[31:24];
						rf[{x[7:5], 2'b01}] <= p32[23:16];
						rf[{x[7:5], 2'b10}] <= p32[15:8];
						rf[{x[7:5], 2'b11}] <= p32[7:0];
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// architectural registers
	// ----------------------------------------------------------------
	// bus writes first, execution after, so the core wins a tie
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			acc              <= 8'h00;
			data_pointer     <= 16'h0000;
			pc               <= 16'h0000;
			upper_port_latch <= RST_P2;
			ctrl             <= RST_CTRL;
			flg              <= '0;
			ill              <= 1'b0;
		end else begin
			if (REG_WR_I) begin
				case (REG_ADDR_I)
					RA_ACC:   acc <= REG_WDATA_I;
					RA_DPH:   data_pointer[15:8] <= REG_WDATA_I;
					RA_DPL:   data_pointer[7:0] <= REG_WDATA_I;
					RA_PCH:   pc[15:8] <= REG_WDATA_I;
					RA_PCL:   pc[7:0] <= REG_WDATA_I;
					RA_P2:    upper_port_latch <= REG_WDATA_I;
					RA_CTRL:  ctrl <= REG_WDATA_I;
					RA_FLAGS: flg <= {REG_WDATA_I[FLG_CY], REG_WDATA_I[FLG_OV],
						REG_WDATA_I[FLG_N], REG_WDATA_I[FLG_Z]};
					RA_STAT:  if (REG_WDATA_I[ST_ILL]) ill <= 1'b0;
					default: ;
				endcase
			end
			if (go) begin
				// pc steps past every taken instruction
				pc <= pc + len;
				if (!legal)
					ill <= 1'b1;  // set wins over a clear
				else begin
					case (op)
						OP_LDPTR: data_pointer <= {x, y};
						OP_MULB: flg <= {1'b0, |p16[15:8], p16[15], ~|p16};
						OP_MULW: flg <= {1'b0, |p32[31:16], p32[31], ~|p32};
						default: ;
					endcase
				end
			end
			if (state == S_CCAP)
				acc <= CODE_DATA_I;
			if (xcap)
				acc <= xin;
		end
	end

	// ----------------------------------------------------------------
	// sequencer and pins
	// ----------------------------------------------------------------
	// every pin is a flop; the phases stretch by the package counts
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			state         <= S_IDLE;
			INSTR_READY_O <= 1'b0;
			CODE_ADDR_O   <= 16'h0000;
			CODE_RD_O     <= 1'b0;
			cnt           <= 3'h0;
			xwr           <= 1'b0;
			xlo           <= 8'h00;
			xhi           <= 8'h00;
			P0_O          <= 8'h00;
			P0_OE_O       <= 1'b0;
			P2_O          <= RST_P2;
			P2_OE_O       <= 1'b1;
			ALE_O         <= 1'b0;
			RD_N_O        <= 1'b1;
			WR_N_O        <= 1'b1;
		end else begin
			CODE_RD_O <= 1'b0;
			unique case (state)
				S_IDLE: begin
					// port2 follows its latch between cycles
					INSTR_READY_O <= 1'b1;
					P2_O          <= upper_port_latch;
					if (go_ok && (op == OP_CTAB_PC || op == OP_CTAB_PTR)) begin
						// pc base is the next address, pc plus len
						CODE_ADDR_O <= (op == OP_CTAB_PC ? pc + len : data_pointer)
							+ {8'h00, acc};
						CODE_RD_O     <= 1'b1;
						INSTR_READY_O <= 1'b0;
						state         <= S_CREQ;
					end else if (go_ok && xop) begin
						// short form keeps the latch on port2
						xwr           <= op[4];
						xlo           <= op[1] ? ri : data_pointer[7:0];
						xhi           <= op[1] ? upper_port_latch : data_pointer[15:8];
						P0_O          <= op[1] ? ri : data_pointer[7:0];
						P2_O          <= op[1] ? upper_port_latch : data_pointer[15:8];
						P0_OE_O       <= 1'b1;
						P2_OE_O       <= 1'b1;
						ALE_O         <= 1'b1;
						cnt           <= ALE_CNT;
						INSTR_READY_O <= 1'b0;
						state         <= S_XADDR;
					end
				end
				S_CREQ: state <= S_CCAP;
				S_CCAP: begin
					INSTR_READY_O <= 1'b1;
					state         <= S_IDLE;
				end
				S_XADDR: begin
					if (cnt != 3'h0)
						cnt <= cnt - 3'h1;
					else begin
						// address falls latched, data takes a port
						ALE_O <= 1'b0;
						cnt   <= STB_CNT;
						RD_N_O <= xwr;
						WR_N_O <= !xwr;
						if (ctrl[CTL_PAGE]) begin
							P2_O    <= acc;
							P2_OE_O <= xwr;
						end else begin
							P0_O    <= acc;
							P0_OE_O <= xwr;
						end
						state <= S_XDATA;
					end
				end
				S_XDATA: begin
					// a read waits until the pins have settled
					if (cnt != 3'h0)
						cnt <= cnt - 3'h1;
					else if (xwr || stable) begin
						RD_N_O <= 1'b1;
						WR_N_O <= 1'b1;
						state  <= S_XEND;
					end
				end
				S_XEND: begin
					// write data held one cycle past the strobe
					P0_OE_O       <= 1'b0;
					P2_O          <= upper_port_latch;
					P2_OE_O       <= 1'b1;
					INSTR_READY_O <= 1'b1;
					state         <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	logic [7:0] fb;  // flags byte
	logic [7:0] sb;  // status byte

	always_comb begin
		fb          = 8'h00;
		fb[FLG_CY]  = flg.cy;
		fb[FLG_OV]  = flg.ov;
		fb[FLG_N]   = flg.n;
		fb[FLG_Z]   = flg.z;
		sb          = 8'h00;
		sb[ST_BUSY] = state != S_IDLE;
		sb[ST_ILL]  = ill;
	end

	// unmapped addresses read zero
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I)
			REG_RDATA_O <= 8'h00;
		else if (!REG_RD_I)
			REG_RDATA_O <= 8'h00;
		else if (!REG_ADDR_I[5])
			REG_RDATA_O <= rf[REG_ADDR_I[4:0]];
		else begin
			case (REG_ADDR_I)
				RA_ACC:   REG_RDATA_O <= acc;
				RA_DPH:   REG_RDATA_O <= data_pointer[15:8];
				RA_DPL:   REG_RDATA_O <= data_pointer[7:0];
				RA_PCH:   REG_RDATA_O <= pc[15:8];
				RA_PCL:   REG_RDATA_O <= pc[7:0];
				RA_P2:    REG_RDATA_O <= upper_port_latch;
				RA_FLAGS: REG_RDATA_O <= fb;
				RA_CTRL:  REG_RDATA_O <= ctrl;
				RA_STAT:  REG_RDATA_O <= sb;
				default:  REG_RDATA_O <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);

	a_ptr_load: assert property (go_ok && op == OP_LDPTR |=>
		data_pointer == {$past(x), $past(y)})
		else $error("pointer load wrong");
	a_ctab_ptr: assert property (go_ok && op == OP_CTAB_PTR && !REG_WR_I |=>
		CODE_RD_O && CODE_ADDR_O == $past(data_pointer + {8'h00, acc})
		&& data_pointer == $past(data_pointer))
		else $error("pointer table address wrong");
	a_ctab_pc: assert property (go_ok && op == OP_CTAB_PC && !REG_WR_I |=>
		CODE_ADDR_O == $past(pc + LEN_ONE + {8'h00, acc}) && pc == $past(pc + LEN_ONE))
		else $error("pc table address wrong");
	a_code_take: assert property (CODE_RD_O |=> ##0 state == S_CCAP
		##1 acc == $past(CODE_DATA_I) || $past(REG_WR_I))
		else $error("code byte not loaded");
	a_high_word: assert property (go_ok && op == OP_HIWORD && !REG_WR_I |=>
		rf[{$past(x[6:4]), 2'b00}] == $past(y)
		&& rf[{$past(x[6:4]), 2'b10}] == $past(rf[{x[6:4], 2'b10}]))
		else $error("high word load wrong");
	a_sign_ext: assert property (go_ok && op == OP_SEXT |=>
		rf[{$past(x[7:4]), 1'b0}] == {8{$past(b8[7])}})
		else $error("sign extension wrong");
	a_zero_ext: assert property (go_ok && op == OP_ZEXT |=>
		rf[{$past(x[7:4]), 1'b0}] == 8'h00 && rf[{$past(x[7:4]), 1'b1}] == $past(b8))
		else $error("zero extension wrong");
	a_xaddr_out: assert property (ALE_O |->
		P0_OE_O && P2_OE_O && P0_O == xlo && P2_O == xhi && RD_N_O && WR_N_O)
		else $error("address phase wrong");
	a_np_data: assert property ($fell(WR_N_O) && !ctrl[CTL_PAGE] |->
		P0_OE_O && P0_O == $past(acc) && !ALE_O)
		else $error("nonpage write data wrong");
	a_pg_data: assert property ($fell(WR_N_O) && ctrl[CTL_PAGE] |->
		P2_OE_O && P2_O == $past(acc) && P0_O == xlo)
		else $error("page write data wrong");
	a_latch_idle: assert property (state == S_IDLE |->
		P2_OE_O && P2_O == $past(upper_port_latch))
		else $error("port2 latch not shown");
	a_mul_byte: assert property (go_ok && op == OP_MULB && !REG_WR_I |=>
		!flg.cy && flg.ov == ($past(p16) > 16'h00FF) && flg.z == ($past(p16) == 16'h0000)
		&& flg.n == $past(p16[15]) && rf[{1'b0, $past(x[7:5]), 1'b0}] == $past(p16[15:8]))
		else $error("byte product wrong");
	a_mul_word: assert property (go_ok && op == OP_MULW && !REG_WR_I |=>
		!flg.cy && flg.ov == ($past(p32) > 32'h0000FFFF) && flg.n == $past(p32[31])
		&& rf[{$past(x[7:5]), 2'b11}] == $past(p32[7:0]))
		else $error("word product wrong");
	a_read_take: assert property (xcap |=> acc == $past(xin) ##1 RD_N_O)
		else $error("read byte lost");
	a_prefix_need: assert property (go && ext && pre == ctrl[CTL_SRC] |=> ill)
		else $error("prefix misuse not flagged");

	c_mul_word: cover property (go_ok && op == OP_MULW);
	c_page_read: cover property ($fell(RD_N_O) && ctrl[CTL_PAGE]);
	c_code_load: cover property (state == S_CCAP);
	c_illegal: cover property (go && !legal);

endmodule : mme_core

/* File: design/mme_pkg.sv */
package mme_pkg;

	// ----------------------------------------------------------------
	// timing of one external data cycle
	// ----------------------------------------------------------------
	localparam int CLK_NS  = 50;   // core clock period, 20 MHz
	localparam int ALE_NS  = 50;   // least address phase length
	localparam int STB_NS  = 150;  // least read/write strobe length
	localparam int ALE_CYC = (ALE_NS + CLK_NS - 1) / CLK_NS;  // rounded up
	localparam int STB_CYC = (STB_NS + CLK_NS - 1) / CLK_NS;  // rounded up
	localparam logic [2:0] ALE_CNT = 3'(ALE_CYC - 1);  // counter preload
	localparam logic [2:0] STB_CNT = 3'(STB_CYC - 1);  // counter preload

	// ----------------------------------------------------------------
	// opcodes of the group
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_PREFIX   = 8'hA5;  // escape prefix byte
	localparam logic [7:0] OP_LDPTR    = 8'h90;  // data_pointer load
	localparam logic [7:0] OP_CTAB_PC  = 8'h83;  // code_table_load, pc base
	localparam logic [7:0] OP_CTAB_PTR = 8'h93;  // code_table_load, pointer base
	localparam logic [7:0] OP_HIWORD   = 8'h7A;  // high_word_immediate_load
	localparam logic [7:0] OP_SEXT     = 8'h1A;  // sign_extend_move
	localparam logic [7:0] OP_ZEXT     = 8'h0A;  // zero_extend_move
	localparam logic [7:0] OP_MULB     = 8'hAC;  // register_product_op, bytes
	localparam logic [7:0] OP_MULW     = 8'hAD;  // register_product_op, words
	localparam logic [7:0] OP_XRD_PTR  = 8'hE0;  // external read, pointer
	localparam logic [7:0] OP_XRD_R0   = 8'hE2;  // external read, indirect 0
	localparam logic [7:0] OP_XRD_R1   = 8'hE3;  // external read, indirect 1
	localparam logic [7:0] OP_XWR_PTR  = 8'hF0;  // external write, pointer
	localparam logic [7:0] OP_XWR_R0   = 8'hF2;  // external write, indirect 0
	localparam logic [7:0] OP_XWR_R1   = 8'hF3;  // external write, indirect 1
	localparam logic [3:0] NIB_HIWORD  = 4'hC;   // low nibble of second byte
	localparam logic [15:0] LEN_ONE    = 16'h0001;  // one-byte step
	localparam logic [15:0] LEN_TWO    = 16'h0002;
	localparam logic [15:0] LEN_THREE  = 16'h0003;
	localparam logic [15:0] LEN_FOUR   = 16'h0004;

	// ----------------------------------------------------------------
	// register map, byte wide
	// ----------------------------------------------------------------
	localparam int         RF_BYTES = 32;      // byte register file size
	localparam logic [5:0] RA_ACC   = 6'h20;   // accumulator
	localparam logic [5:0] RA_DPH   = 6'h21;   // pointer_high_byte
	localparam logic [5:0] RA_DPL   = 6'h22;   // pointer_low_byte
	localparam logic [5:0] RA_PCH   = 6'h23;   // program counter high
	localparam logic [5:0] RA_PCL   = 6'h24;   // program counter low
	localparam logic [5:0] RA_P2    = 6'h25;   // upper_port_latch
	localparam logic [5:0] RA_FLAGS = 6'h26;   // flags
	localparam logic [5:0] RA_CTRL  = 6'h27;   // mode and bank
	localparam logic [5:0] RA_STAT  = 6'h28;   // busy and illegal
	localparam int FLG_CY   = 7;  // carry_bit
	localparam int FLG_OV   = 2;  // result_too_wide_flag
	localparam int FLG_N    = 1;  // negative
	localparam int FLG_Z    = 0;  // zero
	localparam int CTL_SRC  = 0;  // 1: source mode, 0: binary mode
	localparam int CTL_PAGE = 1;  // 1: page mode external cycles
	localparam int CTL_BANK = 2;  // two bits, active register bank
	localparam int ST_BUSY  = 0;  // multi-cycle instruction running
	localparam int ST_ILL   = 1;  // sticky illegal encoding, write 1 clears
	localparam logic [7:0] RST_CTRL = 8'h00;  // binary, nonpage, bank 0
	localparam logic [7:0] RST_P2   = 8'hFF;  // port latch after reset

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] b0;  // first byte fetched
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] b3;
		logic [7:0] b4;
	} mme_instr_t;

	typedef struct packed {
		logic cy;  // carry_bit
		logic ov;  // result_too_wide_flag
		logic n;   // negative
		logic z;   // zero
	} mme_flags_t;

	typedef enum {S_IDLE, S_CREQ, S_CCAP, S_XADDR, S_XDATA, S_XEND} mme_state_t;

endpackage : mme_pkg

/* File: test/mme_xram.sv */
// external data ram on the multiplexed port bus, page or nonpage wiring
module mme_xram (
	input  wire logic       clk_i,   // core clock
	input  wire logic       page_i,  // page mode: data travels on port2
	input  wire logic       ale_i,   // address latch enable
	input  wire logic       rd_n_i,  // read strobe
	input  wire logic       wr_n_i,  // write strobe
	input  wire logic [7:0] p0_d_i,  // port0 drive value
	input  wire logic       p0_oe_i, // port0 driven
	input  wire logic [7:0] p2_d_i,  // port2 drive value
	input  wire logic       p2_oe_i, // port2 driven
	output logic      [7:0] p0_o,    // port0 wire level
	output logic      [7:0] p2_o     // port2 wire level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [0:65535]; // backing store
	logic [15:0] addr;          // address caught during the address phase
	logic [7:0]  last = 8'h00;  // last port0 level, inverted once released
	// released port0 shows a moving value, released port2 the inverse of its drive value
	assign p0_o = p0_oe_i ? p0_d_i : (!rd_n_i && !page_i ? mem[addr] : ~last);
	assign p2_o = p2_oe_i ? p2_d_i : (!rd_n_i && page_i ? mem[addr] : ~p2_d_i);
	// ----------------------------------------------------------------
	// address latch and write capture
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		last <= p0_o;
		if (ale_i) addr <= {p2_d_i, p0_d_i};
		if (!wr_n_i) mem[addr] <= page_i ? p2_d_i : p0_d_i;
	end
endmodule : mme_xram

/* File: test/move_and_multiply_execution_test.sv */
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module move_and_multiply_execution_test
	import mme_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, we = 0, re = 0, vld = 0, pg = 0;
	logic [5:0] adr = '0;
	logic [7:0] wd = '0, rdat, p0, p0i, p2, p2i;
	logic rdy, crd, p0e, p2e, ale, rdn, wrn;
	logic [15:0] caddr;
	mme_instr_t ins = '0;
	int n_errors = 0, n_checks = 0, n_crd = 0;
	always #25 clk = ~clk;
	// every code fetch pulse is counted, one per table load
	always @(posedge clk) if (crd === 1'b1) n_crd++;
	mme_core DUT (.MCLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(adr), .REG_WDATA_I(wd),
		.REG_WR_I(we), .REG_RD_I(re), .REG_RDATA_O(rdat), .INSTR_I(ins),
		.INSTR_VALID_I(vld), .INSTR_READY_O(rdy), .CODE_ADDR_O(caddr), .CODE_RD_O(crd),
		.CODE_DATA_I(caddr[7:0] ^ 8'h5A), .P0_O(p0), .P0_OE_O(p0e), .P0_I(p0i),
		.P2_O(p2), .P2_OE_O(p2e), .P2_I(p2i), .ALE_O(ale), .RD_N_O(rdn), .WR_N_O(wrn));
	mme_xram ram (.clk_i(clk), .page_i(pg), .ale_i(ale), .rd_n_i(rdn), .wr_n_i(wrn), .p0_d_i(p0),
		.p0_oe_i(p0e), .p2_d_i(p2), .p2_oe_i(p2e), .p0_o(p0i), .p2_o(p2i));
	task wr(input logic [5:0] a, input logic [7:0] d);
		// strobe stays up; the next call lowers or renews it
		adr <= a; wd <= d; we <= 1'b1;
		@(posedge clk);
	endtask : wr
	// read data stand only in the cycle after the strobe
	task rd(input logic [5:0] a, input logic [7:0] e);
		adr <= a; re <= 1'b1; we <= 1'b0;
		@(posedge clk); re <= 1'b0;
		@(posedge clk); `CHK(rdat, e)
	endtask : rd
	// offer an instruction, then wait for the core to be ready again
	task run(input logic [39:0] v);
		ins <= mme_instr_t'(v); vld <= 1'b1; we <= 1'b0;
		do @(posedge clk); while (rdy !== 1'b1);
		vld <= 1'b0;
		repeat (30) begin @(posedge clk); if (rdy === 1'b1) break; end
	endtask : run
	task wrap_up;
		if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	initial begin #150000; n_errors++; wrap_up; end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		run({OP_LDPTR, 32'h1234_0000});
		rd(RA_DPH, 8'h12); rd(RA_DPL, 8'h34);
		wr(RA_ACC, 8'h05); run({OP_CTAB_PTR, 32'h0});
		`CHK(caddr, 16'h1239)
		rd(RA_ACC, 8'h63); rd(RA_DPL, 8'h34);
		run({OP_CTAB_PC, 32'h0});
		`CHK(caddr, 16'h0068)
		run({OP_XWR_PTR, 32'h0}); `CHK(ram.mem[16'h1234], 8'h32)
		wr(RA_ACC, 8'h00); run({OP_XRD_PTR, 32'h0});
		rd(RA_ACC, 8'h32);
		run({OP_MULB, 8'h45, 24'h0}); rd(RA_STAT, 8'h02);
		wr(6'h04, 8'h50); wr(6'h05, 8'hA0); wr(6'h00, 8'h85); wr(RA_FLAGS, 8'h80);
		run({OP_PREFIX, OP_MULB, 8'h45, 16'h0});
		rd(6'h04, 8'h32); rd(6'h05, 8'h00);
		rd(RA_FLAGS, 8'h04);
		run({OP_PREFIX, OP_SEXT, 8'h30, 16'h0});
		rd(6'h06, 8'hFF); rd(6'h07, 8'h85);
		run({OP_PREFIX, OP_ZEXT, 8'h40, 16'h0});
		rd(6'h08, 8'h00); rd(6'h09, 8'h85);
		run({OP_PREFIX, OP_HIWORD, 8'h1C, 8'h11, 8'h22});
		rd(6'h04, 8'h11); rd(6'h05, 8'h22); rd(6'h07, 8'h85);
		wr(RA_STAT, 8'h02); wr(RA_CTRL, 8'h01); wr(RA_FLAGS, 8'h80);
		wr(6'h0A, 8'h02); wr(6'h0B, 8'h00);
		run({OP_MULW, 8'h45, 24'h0}); rd(RA_STAT, 8'h00);
		rd(6'h08, 8'h00); rd(6'h09, 8'h01);
		rd(6'h0A, 8'h0A); rd(6'h0B, 8'h00);
		rd(RA_FLAGS, 8'h04);
		run({OP_PREFIX, OP_SEXT, 8'h30, 16'h0}); rd(RA_STAT, 8'h02);
		run({OP_XWR_R0, 32'h0}); `CHK(ram.mem[16'hFF85], 8'h32)
		pg <= 1'b1; wr(RA_CTRL, 8'h03); wr(RA_ACC, 8'h00);
		run({OP_XRD_R0, 32'h0}); rd(RA_ACC, 8'h32);
		wr(RA_ACC, 8'h77); run({OP_XWR_PTR, 32'h0});
		`CHK(ram.mem[16'h1234], 8'h77)
		`CHK(n_crd, 2)
		wrap_up;
	end
endmodule : move_and_multiply_execution_test
